// [rtl/db2_defines.vh]
// Purpose: Shared constants of the burst-of-two DDR SRAM port.
// Assumes: Included by bare name; definitions only.
// Notes: Organisation figures are kept for all four widths.
//
// Notes on behaviour
// - Read address first half, write address second.
// - Selects sampled in first half only.
// - Masks sampled each half with their data.
// - Every access moves exactly two words.
// - One read and one write per cycle.
// - K rise captures selects, masks, read address, word0.
// - K_n rise captures masks, write address, word1.
// - Both output clocks high selects single-clock mode.
// - DLL on: words aligned to output clock edges.
// - DLL off: output register adds clock delay.
// - Echo clocks from output or input clock pair.
// - Positive edge raises true echo, negative raises comp.
// - Burst stored as one wide word, fixed order.
// - Masks suppress bytes or a whole burst word.
// - Read taken at K rise, returned on output clocks.
// - Both halves written to captured write address.
// - Address 20, 19 or 18 bits by organisation.
// - Mask lines 1, 2, 4; x8 uses 2 nibble lines.
// - Data ports 8, 9, 18 or 36 bits wide.
// - Read data driven only while valid; echo free.
// - Deselected read completes, then outputs release.
// - Masked lanes keep contents; lane 0 lowest.
`ifndef DB2_DEFINES_VH
`define DB2_DEFINES_VH

// ****************************************
// Organisation
// ****************************************
`define DB2_BURST_LEN 2
`define DB2_DATA_W_X8 8
`define DB2_DATA_W_X9 9
`define DB2_DATA_W_X18 18
`define DB2_DATA_W_X36 36
`define DB2_ADDR_W_X8 20
`define DB2_ADDR_W_X9 20
`define DB2_ADDR_W_X18 19
`define DB2_ADDR_W_X36 18
`define DB2_MASK_W_X8 2
`define DB2_MASK_W_X9 1
`define DB2_MASK_W_X18 2
`define DB2_MASK_W_X36 4

// ****************************************
// Timing and reset values
// ****************************************
`define DB2_RD_LAT_HALF 3
`define DB2_DLL_OFF_DLY 1
`define DB2_SETTLE_CYC 3
`define DB2_SYNC_RST 1'b0

`endif

// [rtl/db2_sync.v]
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Input is asynchronous to i_clock.
// Notes: First stage is read by the second stage only.
`timescale 1ns/1ps
`include "db2_defines.vh"

module db2_sync #(
   parameter W = 1
) (
   // Clock and reset
   input wire i_clock,
   input wire i_rst_n,
   // Data
   input wire [W-1:0] i_d,
   output reg [W-1:0] o_q
);

   reg [W-1:0] meta_r;

   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         meta_r <= {W{`DB2_SYNC_RST}};
         o_q <= {W{`DB2_SYNC_RST}};
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end

endmodule // db2_sync

// [rtl/db2_port.v]
// Purpose: Port logic of a burst-of-two DDR SRAM, sampled clocks.
// Assumes: Link clocks far slower than i_clock; pins synchronised.
// Notes: Organisation set by DATA_W, ADDR_W and MASK_W.
`timescale 1ns/1ps
`include "db2_defines.vh"

module db2_port #(
   parameter DATA_W = `DB2_DATA_W_X36,
   parameter ADDR_W = `DB2_ADDR_W_X36,
   parameter MASK_W = `DB2_MASK_W_X36,
   parameter MEM_AW = ADDR_W,
   parameter RD_LAT_HALF = `DB2_RD_LAT_HALF
) (
   // System clock and reset
   input wire i_clock,
   input wire i_rst_n,
   // Input clock pair
   input wire i_k,
   input wire i_k_n,
   // Output clock pair
   input wire i_c,
   input wire i_c_n,
   // DLL control, low turns DLL off
   input wire i_dll_on_n_off,
   // Request pins
   input wire i_rd_sel_n,
   input wire i_wr_sel_n,
   input wire [ADDR_W-1:0] i_shared_addr,
   input wire [MASK_W-1:0] i_byte_mask_n,
   input wire [DATA_W-1:0] i_wdata,
   // Read data and echo clocks
   output reg [DATA_W-1:0] o_q,
   output reg o_q_oe,
   output reg o_echo_clock_true,
   output reg o_echo_clock_comp
);

   // ****************************************
   // Constants and helpers
   // ****************************************
   localparam LANE_W = DATA_W / MASK_W;
   localparam WIDE_W = `DB2_BURST_LEN * DATA_W;
   localparam MEM_DEPTH = 1 << MEM_AW;
   localparam PIN_W = 7 + ADDR_W + MASK_W + DATA_W;

   // Lane write enable from an active-low mask
   function lane_en;
      input [MASK_W-1:0] mask_n;
      input integer lane;
      begin
         lane_en = ~mask_n[lane];
      end
   endfunction

   // ****************************************
   // Pin synchronisation
   // ****************************************
   wire [PIN_W-1:0] pin_raw;
   wire [PIN_W-1:0] pin_s;

   assign pin_raw = {i_k, i_k_n, i_c, i_c_n, i_dll_on_n_off,
                     i_rd_sel_n, i_wr_sel_n, i_shared_addr,
                     i_byte_mask_n, i_wdata};

   db2_sync #(
      .W(PIN_W)
   ) u_sync (
      .i_clock(i_clock),
      .i_rst_n(i_rst_n),
      .i_d(pin_raw),
      .o_q(pin_s)
   );

   wire k_s;
   wire kn_s;
   wire c_s;
   wire cn_s;
   wire dll_on_s;
   wire rd_sel_n_s;
   wire wr_sel_n_s;
   wire [ADDR_W-1:0] addr_s;
   wire [MASK_W-1:0] mask_n_s;
   wire [DATA_W-1:0] wdata_s;

   assign k_s = pin_s[PIN_W-1];
   assign kn_s = pin_s[PIN_W-2];
   assign c_s = pin_s[PIN_W-3];
   assign cn_s = pin_s[PIN_W-4];
   assign dll_on_s = pin_s[PIN_W-5];
   assign rd_sel_n_s = pin_s[PIN_W-6];
   assign wr_sel_n_s = pin_s[PIN_W-7];
   assign addr_s = pin_s[ADDR_W+MASK_W+DATA_W-1:MASK_W+DATA_W];
   assign mask_n_s = pin_s[MASK_W+DATA_W-1:DATA_W];
   assign wdata_s = pin_s[DATA_W-1:0];

   // ****************************************
   // Edge detection
   // ****************************************
   reg k_d_r;
   reg kn_d_r;
   reg c_d_r;
   reg cn_d_r;
   reg [1:0] settle_r;
   wire live;
   wire k_rise;
   wire kn_rise;
   wire c_rise;
   wire cn_rise;
   wire single_mode;
   wire out_pos;
   wire out_neg;

   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         k_d_r <= 1'b0;
         kn_d_r <= 1'b0;
         c_d_r <= 1'b0;
         cn_d_r <= 1'b0;
         settle_r <= 2'h0;
      end else begin
         k_d_r <= k_s;
         kn_d_r <= kn_s;
         c_d_r <= c_s;
         cn_d_r <= cn_s;
         if (settle_r != `DB2_SETTLE_CYC)
            settle_r <= settle_r + 2'h1;
      end
   end

   // Edges ignored until the synchroniser holds real pin levels
   assign live = (settle_r == `DB2_SETTLE_CYC);
   assign k_rise = live & k_s & ~k_d_r;
   assign kn_rise = live & kn_s & ~kn_d_r;
   assign c_rise = live & c_s & ~c_d_r;
   assign cn_rise = live & cn_s & ~cn_d_r;

   // Output clocks both held high means single-clock mode
   assign single_mode = c_s & cn_s & c_d_r & cn_d_r;
   assign out_pos = single_mode ? k_rise : c_rise;
   assign out_neg = single_mode ? kn_rise : cn_rise;

   // ****************************************
   // Request decode
   // ****************************************
   wire rd_take;
   wire wr_take;

   // Selects count only at a detected K rise
   assign rd_take = k_rise & ~rd_sel_n_s;
   assign wr_take = k_rise & ~wr_sel_n_s;

   // ****************************************
   // Storage
   // ****************************************
   // Rows are not reset; unwritten rows read back unknown
   reg [WIDE_W-1:0] mem [0:MEM_DEPTH-1];

   // ****************************************
   // Write capture
   // ****************************************
   reg wr_act_r;
   reg [DATA_W-1:0] wr_word0_r;
   reg [MASK_W-1:0] wr_mask0_n_r;

   // First half: select, masks and first word at K rise
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         wr_act_r <= 1'b0;
         wr_word0_r <= {DATA_W{1'b0}};
         wr_mask0_n_r <= {MASK_W{1'b1}};
      end else if (k_rise) begin
         wr_act_r <= wr_take;
         wr_word0_r <= wdata_s;
         wr_mask0_n_r <= mask_n_s;
      end else if (kn_rise) begin
         wr_act_r <= 1'b0;
      end
   end

   // Second half: write address, masks, second word, then commit
   wire [MEM_AW-1:0] wr_idx;

   assign wr_idx = addr_s[MEM_AW-1:0];

   // Commit only when the first half was taken
   wire wr_commit;
   assign wr_commit = kn_rise & wr_act_r;

   integer wl;

   always @(posedge i_clock) begin
      if (wr_commit) begin
         for (wl = 0; wl < MASK_W; wl = wl + 1) begin
            if (lane_en(wr_mask0_n_r, wl))
               mem[wr_idx][wl*LANE_W +: LANE_W] <= wr_word0_r[wl*LANE_W +: LANE_W];
            if (lane_en(mask_n_s, wl))
               mem[wr_idx][DATA_W+wl*LANE_W +: LANE_W] <= wdata_s[wl*LANE_W +: LANE_W];
         end
      end
   end

   // ****************************************
   // Read capture
   // ****************************************
   reg rd_pend_r;
   reg rd_pend_nxt;
   reg [WIDE_W-1:0] rd_word_r;
   reg hi_pend_r;
   reg hi_pend_nxt;
   reg [DATA_W-1:0] hi_word_r;
   wire [MEM_AW-1:0] rd_idx;

   assign rd_idx = addr_s[MEM_AW-1:0];

   // Word fetched at K rise, independent of the write half
   always @(posedge i_clock) begin
      if (rd_take)
         rd_word_r <= mem[rd_idx];
   end

   // Pending burst handed to the output side
   always @* begin
      rd_pend_nxt = rd_pend_r;
      hi_pend_nxt = hi_pend_r;
      if (out_pos) begin
         hi_pend_nxt = rd_pend_r;
         rd_pend_nxt = 1'b0;
      end else if (out_neg) begin
         hi_pend_nxt = 1'b0;
      end
      // A new request wins over the hand-off
      if (rd_take)
         rd_pend_nxt = 1'b1;
   end

   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         rd_pend_r <= 1'b0;
         hi_pend_r <= 1'b0;
         hi_word_r <= {DATA_W{1'b0}};
      end else begin
         rd_pend_r <= rd_pend_nxt;
         hi_pend_r <= hi_pend_nxt;
         if (out_pos)
            hi_word_r <= rd_word_r[WIDE_W-1:DATA_W];
      end
   end

   // ****************************************
   // Output pipeline in output half-cycles
   // ****************************************
   reg [RD_LAT_HALF-1:0] pv_r;
   reg [DATA_W-1:0] pd_r [0:RD_LAT_HALF-1];
   reg echo_r;
   wire out_edge;

   assign out_edge = out_pos | out_neg;

   // Stage 0 takes word0 on a positive edge, word1 on a negative one
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         pv_r[0] <= 1'b0;
         pd_r[0] <= {DATA_W{1'b0}};
      end else if (out_pos) begin
         pv_r[0] <= rd_pend_r;
         pd_r[0] <= rd_word_r[DATA_W-1:0];
      end else if (out_neg) begin
         pv_r[0] <= hi_pend_r;
         pd_r[0] <= hi_word_r;
      end
   end

   genvar gs;

   generate
      for (gs = 1; gs < RD_LAT_HALF; gs = gs + 1) begin : g_stage
         always @(posedge i_clock) begin
            if (!i_rst_n) begin
               pv_r[gs] <= 1'b0;
               pd_r[gs] <= {DATA_W{1'b0}};
            end else if (out_edge) begin
               pv_r[gs] <= pv_r[gs-1];
               pd_r[gs] <= pd_r[gs-1];
            end
         end
      end
   endgenerate

   // Echo phase follows the last output clock edge
   always @(posedge i_clock) begin
      if (!i_rst_n)
         echo_r <= 1'b0;
      else if (out_pos)
         echo_r <= 1'b1;
      else if (out_neg)
         echo_r <= 1'b0;
   end

   // ****************************************
   // Output register and DLL bypass
   // ****************************************
   reg [DATA_W-1:0] q_nxt;
   reg q_oe_nxt;
   reg [DATA_W-1:0] q_dly_r;
   reg q_oe_dly_r;
   reg echo_dly_r;
   wire echo_sel;

   always @* begin
      q_nxt = pd_r[RD_LAT_HALF-1];
      q_oe_nxt = pv_r[RD_LAT_HALF-1];
      if (!dll_on_s) begin
         q_nxt = q_dly_r;
         q_oe_nxt = q_oe_dly_r;
      end
   end

   assign echo_sel = dll_on_s ? echo_r : echo_dly_r;

   // Extra stage stands for the clock-to-data delay with DLL off
   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         q_dly_r <= {DATA_W{1'b0}};
         q_oe_dly_r <= 1'b0;
         echo_dly_r <= 1'b0;
      end else begin
         q_dly_r <= pd_r[RD_LAT_HALF-1];
         q_oe_dly_r <= pv_r[RD_LAT_HALF-1];
         echo_dly_r <= echo_r;
      end
   end

   always @(posedge i_clock) begin
      if (!i_rst_n) begin
         o_q <= {DATA_W{1'b0}};
         o_q_oe <= 1'b0;
         o_echo_clock_true <= 1'b0;
         o_echo_clock_comp <= 1'b1;
      end else begin
         o_q <= q_nxt;
         o_q_oe <= q_oe_nxt;
         o_echo_clock_true <= echo_sel;
         o_echo_clock_comp <= ~echo_sel;
      end
   end

endmodule // db2_port

// [tb/db2_link_model.sv]
// Purpose: Controller-side clock source for the port.
// Assumes: Output pair is a delayed copy of the input pair.
// Notes: Clocks stand still at K low while not running.
`timescale 1ns/1ps
module db2_link_model (
   // Control
   input wire i_run,
   input wire i_single,
   // Link clocks
   output reg o_k,
   output wire o_k_n,
   output wire o_c,
   output wire o_c_n
);
   // ***
   // Clock pairs
   // ***
   reg c_r = 1'b0;
   initial o_k = 1'b0;
   initial begin
      #37;
      forever begin
         #400;
         o_k = i_run ? ~o_k : 1'b0;
      end
   end
   always @(o_k) c_r <= #150 o_k;
   assign o_k_n = ~o_k;
   // Both output clocks tied high in single mode
   assign o_c = i_single | c_r;
   assign o_c_n = i_single | ~c_r;
endmodule // db2_link_model

// [tb/db2_port_assertions.sv]
// Purpose: Output timing checks of the port.
// Assumes: Pins seen raw, one clock domain.
// Notes: Edge ages counted from raw pin samples.
`timescale 1ns/1ps
module db2_port_assertions #(
   parameter DATA_W = 36
) (
   input wire i_clock,
   input wire i_rst_n,
   input wire i_k,
   input wire i_k_n,
   input wire i_c,
   input wire i_c_n,
   input wire i_rd_sel_n,
   input wire i_dll_on_n_off,
   input wire [DATA_W-1:0] o_q,
   input wire o_q_oe,
   input wire o_echo_clock_true,
   input wire o_echo_clock_comp
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   // ***
   // Edge ages
   // ***
   reg pk_r, pkn_r, pc_r, pcn_r;
   reg [3:0] pos_age_r, neg_age_r;
   reg [5:0] rd_age_r;
   // Single mode only once both output clocks stayed high two samples
   wire single = i_c & i_c_n & pc_r & pcn_r;
   wire pos_e = single ? (i_k & ~pk_r) : (i_c & ~pc_r);
   wire neg_e = single ? (i_k_n & ~pkn_r) : (i_c_n & ~pcn_r);
   always @(posedge i_clock) begin
      pk_r <= i_k;
      pkn_r <= i_k_n;
      pc_r <= i_c;
      pcn_r <= i_c_n;
      if (!i_rst_n) begin
         pos_age_r <= 4'hf;
         neg_age_r <= 4'hf;
         rd_age_r <= 6'h3f;
      end else begin
         pos_age_r <= pos_e ? 4'h0 : pos_age_r + {3'h0, pos_age_r != 4'hf};
         neg_age_r <= neg_e ? 4'h0 : neg_age_r + {3'h0, neg_age_r != 4'hf};
         rd_age_r <= (i_k & ~pk_r & ~i_rd_sel_n) ? 6'h0 : rd_age_r + {5'h0, rd_age_r != 6'h3f};
      end
   end
   // ***
   // Properties
   // ***
   a_echo_comp_inv: assert property (o_echo_clock_comp == ~o_echo_clock_true)
      else $error("echo pair not complementary");
   a_echo_rise_pos: assert property ($rose(o_echo_clock_true) |-> pos_age_r inside {[1:7]})
      else $error("true echo rose without positive edge");
   a_echo_fall_neg: assert property ($fell(o_echo_clock_true) |-> neg_age_r inside {[1:7]})
      else $error("true echo fell without negative edge");
   a_oe_after_read: assert property ($rose(o_q_oe) |-> rd_age_r inside {[4:40]})
      else $error("output enabled without read");
   a_oe_on_pos: assert property ($rose(o_q_oe) |-> $rose(o_echo_clock_true))
      else $error("first word off positive edge");
   a_oe_off_pos: assert property ($fell(o_q_oe) |-> $rose(o_echo_clock_true))
      else $error("release off positive edge");
   a_q_only_edge: assert property (o_q_oe && $past(o_q_oe) && !$stable(o_q) |-> !$stable(o_echo_clock_true))
      else $error("data moved between edges");
   a_burst_two_word: assert property ($rose(o_q_oe) |-> o_q_oe throughout (1'b1 ##[1:8] $fell(o_echo_clock_true)))
      else $error("burst shorter than two words");
   c_read: cover property ($rose(o_q_oe));
   c_single: cover property (single && $rose(o_q_oe));
   c_dll_off: cover property (!i_dll_on_n_off && $rose(o_q_oe));
endmodule // db2_port_assertions
bind db2_port db2_port_assertions #(.DATA_W(DATA_W)) db2_port_assertions_i (
   .i_clock(i_clock), .i_rst_n(i_rst_n), .i_k(i_k), .i_k_n(i_k_n), .i_c(i_c), .i_c_n(i_c_n),
   .i_rd_sel_n(i_rd_sel_n), .i_dll_on_n_off(i_dll_on_n_off), .o_q(o_q), .o_q_oe(o_q_oe),
   .o_echo_clock_true(o_echo_clock_true), .o_echo_clock_comp(o_echo_clock_comp));

// [tb/testbench.sv]
// Purpose: Scenario bench of the burst-of-two port.
// Assumes: Default 36-bit organisation, small memory.
// Notes: Pins change one clock after each link edge.
`timescale 1ns/1ps
module testbench;
   reg i_clock = 1'b0;
   reg i_rst_n = 1'b0;
   reg run = 1'b0;
   reg single = 1'b0;
   reg dll_n = 1'b1;
   reg rd_n = 1'b1;
   reg wr_n = 1'b1;
   reg [17:0] addr = 18'h0;
   reg [3:0] mask = 4'hf;
   reg [35:0] wd = 36'h0;
   wire k, k_n, c, c_n, oe, et, ec;
   wire [35:0] q;
   integer fails = 0;
   integer cmp_count = 0;
   localparam [35:0] A0 = 36'h123456789, A1 = 36'h0fedcba98, B0 = 36'h5a5a5a5a5, B1 = 36'ha5a5a5a5a;
   localparam [35:0] N0 = 36'hacbdcefdf;
   always #50 i_clock = ~i_clock;
   db2_link_model db2_link_model_i (.i_run(run), .i_single(single), .o_k(k), .o_k_n(k_n), .o_c(c), .o_c_n(c_n));
   db2_port #(.MEM_AW(6)) db2_port_i (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_k(k), .i_k_n(k_n),
      .i_c(c), .i_c_n(c_n), .i_dll_on_n_off(dll_n), .i_rd_sel_n(rd_n), .i_wr_sel_n(wr_n),
      .i_shared_addr(addr), .i_byte_mask_n(mask), .i_wdata(wd), .o_q(q), .o_q_oe(oe),
      .o_echo_clock_true(et), .o_echo_clock_comp(ec));
   // ***
   // Helpers
   // ***
   task chk(input [35:0] seen, input [35:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            fails = fails + 1;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
         end
      end
   endtask
   function [35:0] mrg(input [35:0] o, input [35:0] n, input [3:0] m);
      integer i;
      begin
         mrg = o;
         for (i = 0; i < 4; i = i + 1)
            if (!m[i]) mrg[i*9 +: 9] = n[i*9 +: 9];
      end
   endfunction
   // One link cycle: first half, then second half
   task cyc(input r, input [17:0] ra, input w, input [17:0] wa, input [3:0] m0, input [35:0] d0,
            input [3:0] m1, input [35:0] d1);
      begin
         @(posedge k_n);
         @(posedge i_clock);
         rd_n <= r;
         wr_n <= w;
         addr <= ra;
         mask <= m0;
         wd <= d0;
         @(posedge k);
         @(posedge i_clock);
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         addr <= wa;
         mask <= m1;
         wd <= d1;
      end
   endtask
   task await(input sel, input val);
      integer n;
      begin
         n = 0;
         while ((sel ? et : oe) !== val && n < 80) begin
            @(negedge i_clock);
            n = n + 1;
         end
         chk(n < 80, 36'h1);
      end
   endtask
   task collect(input [35:0] e0, input [35:0] e1);
      begin
         await(1'b0, 1'b1);
         chk(q, e0);
         chk(et, 36'h1);
         chk(ec, 36'h0);
         await(1'b1, 1'b0);
         chk(q, e1);
         await(1'b0, 1'b0);
      end
   endtask
   task rd(input [17:0] ra);
      cyc(1'b0, ra, 1'b1, 18'h0, 4'hf, 36'h0, 4'hf, 36'h0);
   endtask
   // ***
   // Scenarios
   // ***
   task t_write_read;
      begin
         cyc(1'b1, 18'h0, 1'b0, 18'h1, 4'h0, A0, 4'h0, A1);
         rd(18'h1);
         collect(A0, A1);
      end
   endtask
   task t_concurrent;
      begin
         cyc(1'b0, 18'h1, 1'b0, 18'h2, 4'h0, B0, 4'h0, B1);
         collect(A0, A1);
         rd(18'h2);
         collect(B0, B1);
      end
   endtask
   task t_masks;
      begin
         cyc(1'b1, 18'h2, 1'b0, 18'h1, 4'ha, N0, 4'hf, 36'h0);
         rd(18'h1);
         collect(mrg(A0, N0, 4'ha), A1);
      end
   endtask
   task t_single;
      begin
         @(posedge i_clock);
         run <= 1'b0;
         repeat (20) @(posedge i_clock);
         single <= 1'b1;
         repeat (4) @(posedge i_clock);
         run <= 1'b1;
         rd(18'h2);
         collect(B0, B1);
      end
   endtask
   task t_dll_off;
      begin
         @(posedge i_clock);
         dll_n <= 1'b0;
         rd(18'h1);
         collect(mrg(A0, N0, 4'ha), A1);
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, fails);
         if (fails == 0 && cmp_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      #300000;
      fails = fails + 1;
      conclude;
   end
   initial begin
      repeat (10) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (8) @(posedge i_clock);
      run <= 1'b1;
      t_write_read;
      t_concurrent;
      t_masks;
      t_single;
      t_dll_off;
      conclude;
   end
endmodule // testbench
